// ===== core/shgb_gpio_block.sv
`timescale 1ns/1ps
`default_nettype none
module shgb_gpio_block
  import shgb_pkg::*;
#(
  parameter logic [5:0] ADDR_BASE = ADDR_BASE_DEF
)(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       smb_addr_lsb_strap,
  input  wire logic       primary_smb_clk_in,
  output logic            primary_smb_clk_out,
  output logic            primary_smb_clk_oe,
  input  wire logic       primary_smb_data_in,
  output logic            primary_smb_data_out,
  output logic            primary_smb_data_oe,
  input  wire logic       seg1_smb_clk_in,
  output logic            seg1_smb_clk_out,
  output logic            seg1_smb_clk_oe,
  input  wire logic       seg1_smb_data_in,
  output logic            seg1_smb_data_out,
  output logic            seg1_smb_data_oe,
  input  wire logic       seg2_smb_clk_in,
  output logic            seg2_smb_clk_out,
  output logic            seg2_smb_clk_oe,
  input  wire logic       seg2_smb_data_in,
  output logic            seg2_smb_data_out,
  output logic            seg2_smb_data_oe,
  output logic            smb_irq_out_n,
  output logic            smb_irq_out_n_oe,
  output logic            wake_pending,
  input  wire logic [7:0] io_port_a_in,
  output logic      [7:0] io_port_a_out,
  output logic      [7:0] io_port_a_oe,
  input  wire logic [7:0] io_port_b_in,
  output logic      [7:0] io_port_b_out,
  output logic      [7:0] io_port_b_oe,
  input  wire logic [7:0] io_port_c_in,
  output logic      [7:0] io_port_c_out,
  output logic      [7:0] io_port_c_oe,
  input  wire logic [7:0] io_port_d_in,
  output logic      [7:0] io_port_d_out,
  output logic      [7:0] io_port_d_oe
);

  logic [NUM_PINS-1:0] pin_in_vec, pin_out_vec, pin_oe_vec, pin_state, edge_vec;
  logic [NUM_PINS-1:0] level_reg, dir_reg, od_reg, wake_en_reg, wake_sts_reg, clr_vec;
  logic [1:0]          seg_join_reg;
  logic                dir_touched_reg;
  logic                strap_s1_reg, strap_s2_reg, strap_done_reg, addr_lsb_reg;
  logic [1:0]          strap_cnt_reg;
  logic [1:0]          bus_s1_reg, bus_s2_reg, bus_prev_reg;
  logic [3:0]          seg_s1_reg, seg_s2_reg, seg_in_vec, p2s_reg, s2p_reg;
  logic [1:0]          prim_oe_reg;
  logic                low_reg, irq_reg;
  shgb_state_e         st_reg;
  logic [2:0]          bit_cnt_reg;
  logic [7:0]          shreg_reg, cmd_reg, rd_byte;
  logic [1:0]          phase_reg;
  logic                rw_reg, rx_full_reg, nack_reg, sda_drv_reg;
  logic                scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
  logic                addr_match, rx_done, wr_en, rd_load;
  logic [5:0]          grp;
  logic [4:0]          lane;

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  assign pin_in_vec = {io_port_d_in, io_port_c_in, io_port_b_in, io_port_a_in};
  assign {io_port_d_out, io_port_c_out, io_port_b_out, io_port_a_out} = pin_out_vec;
  assign {io_port_d_oe, io_port_c_oe, io_port_b_oe, io_port_a_oe}     = pin_oe_vec;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    shgb_pin_cell u_cell (
      .clock      (clock),
      .nrst       (nrst),
      .pin_in     (pin_in_vec[i]),
      .dir        (dir_reg[i]),
      .open_drain (od_reg[i]),
      .level      (level_reg[i]),
      .pin_out    (pin_out_vec[i]),
      .pin_oe     (pin_oe_vec[i]),
      .state      (pin_state[i]),
      .edge_seen  (edge_vec[i])
    );
  end

  // ----------------------------------------------------------------
  // Address strap
  // ----------------------------------------------------------------
  // capture strap once after reset; weak pull-down lives in the pad
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_s1_reg   <= 1'h0;
      strap_s2_reg   <= 1'h0;
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'h0;
      addr_lsb_reg   <= 1'h0;
    end else begin
      strap_s1_reg <= smb_addr_lsb_strap;
      strap_s2_reg <= strap_s1_reg;
      if (!strap_done_reg) begin
        if (strap_cnt_reg == STRAP_SETTLE) begin
          addr_lsb_reg   <= strap_s2_reg;
          strap_done_reg <= 1'h1;
        end else begin
          strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus line sampling
  // ----------------------------------------------------------------
  // all sampling on the standby crystal clock
  assign seg_in_vec = {seg2_smb_data_in, seg2_smb_clk_in, seg1_smb_data_in, seg1_smb_clk_in};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_s1_reg   <= 2'h3;
      bus_s2_reg   <= 2'h3;
      bus_prev_reg <= 2'h3;
      seg_s1_reg   <= 4'hF;
      seg_s2_reg   <= 4'hF;
    end else begin
      bus_s1_reg   <= {primary_smb_data_in, primary_smb_clk_in};
      bus_s2_reg   <= bus_s1_reg;
      bus_prev_reg <= bus_s2_reg;
      seg_s1_reg   <= seg_in_vec;
      seg_s2_reg   <= seg_s1_reg;
    end
  end

  assign scl        = bus_s2_reg[0];
  assign sda        = bus_s2_reg[1];
  assign scl_rise   = scl & ~bus_prev_reg[0];
  assign scl_fall   = ~scl & bus_prev_reg[0];
  assign start_cond = strap_done_reg & scl & bus_prev_reg[0] & bus_prev_reg[1] & ~sda;
  assign stop_cond  = scl & bus_prev_reg[0] & ~bus_prev_reg[1] & sda;

  // ----------------------------------------------------------------
  // SMBus slave
  // ----------------------------------------------------------------
  assign grp        = cmd_reg[7:2];
  assign lane       = {cmd_reg[1:0], 3'h0};
  assign addr_match = shreg_reg[7:1] == {ADDR_BASE, addr_lsb_reg};
  assign rx_done    = (st_reg == ST_RX) && scl_fall && rx_full_reg;
  assign wr_en      = rx_done && (phase_reg == PHASE_DATA);
  assign rd_load    = scl_fall && (((st_reg == ST_RX_ACK) && (phase_reg == PHASE_ADDR) && rw_reg)
                      || ((st_reg == ST_TX_ACK) && !nack_reg));

  always_comb begin
    rd_byte = 8'h00;
    case (grp)
      GRP_STATE: rd_byte = pin_state[lane +: PORT_W];
      GRP_LEVEL: rd_byte = level_reg[lane +: PORT_W];
      GRP_DIR:   rd_byte = dir_reg[lane +: PORT_W];
      GRP_OD:    rd_byte = od_reg[lane +: PORT_W];
      GRP_WSTS:  rd_byte = wake_sts_reg[lane +: PORT_W];
      GRP_WEN:   rd_byte = wake_en_reg[lane +: PORT_W];
      GRP_SEG:   rd_byte = (cmd_reg[1:0] == 2'h0) ? {6'h00, seg_join_reg} : 8'h00;
      default:   rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shreg_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      phase_reg   <= PHASE_ADDR;
      rw_reg      <= 1'h0;
      rx_full_reg <= 1'h0;
      nack_reg    <= 1'h0;
      sda_drv_reg <= 1'h0;
    end else if (start_cond) begin
      st_reg      <= ST_RX;
      bit_cnt_reg <= 3'h0;
      phase_reg   <= PHASE_ADDR;
      rx_full_reg <= 1'h0;
      sda_drv_reg <= 1'h0;
    end else if (stop_cond) begin
      st_reg      <= ST_IDLE;
      sda_drv_reg <= 1'h0;
    end else begin
      if (rd_load) begin
        shreg_reg   <= rd_byte;
        sda_drv_reg <= ~rd_byte[7];
        bit_cnt_reg <= 3'h0;
        st_reg      <= ST_TX;
        phase_reg   <= PHASE_DATA;
        cmd_reg     <= cmd_reg + 8'h01;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
          end
          ST_RX: begin
            if (scl_rise && !rx_full_reg) begin
              shreg_reg   <= {shreg_reg[6:0], sda};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              rx_full_reg <= (bit_cnt_reg == BIT_LAST);
            end else if (rx_done) begin
              if ((phase_reg == PHASE_ADDR) && !addr_match) begin
                st_reg <= ST_IDLE;
              end else begin
                st_reg      <= ST_RX_ACK;
                sda_drv_reg <= 1'h1;
                if (phase_reg == PHASE_ADDR) rw_reg <= shreg_reg[0];
                if (phase_reg == PHASE_CMD) cmd_reg <= shreg_reg;
                if (wr_en) cmd_reg <= cmd_reg + 8'h01;
              end
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              sda_drv_reg <= 1'h0;
              rx_full_reg <= 1'h0;
              bit_cnt_reg <= 3'h0;
              st_reg      <= ST_RX;
              phase_reg   <= (phase_reg == PHASE_ADDR) ? PHASE_CMD : PHASE_DATA;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == BIT_LAST) begin
                sda_drv_reg <= 1'h0;
                st_reg      <= ST_TX_ACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shreg_reg   <= {shreg_reg[6:0], 1'h0};
                sda_drv_reg <= ~shreg_reg[6];
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) nack_reg <= sda;
            if (scl_fall) st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_reg       <= ZERO32;
      dir_reg         <= ZERO32;
      od_reg          <= ZERO32;
      wake_en_reg     <= ZERO32;
      seg_join_reg    <= 2'h0;
      dir_touched_reg <= 1'h0;
    end else if (wr_en) begin
      case (grp)
        GRP_LEVEL: level_reg[lane +: PORT_W] <= shreg_reg;
        GRP_DIR: begin
          dir_reg[lane +: PORT_W] <= shreg_reg;
          dir_touched_reg         <= 1'h1;
        end
        GRP_OD:  od_reg[lane +: PORT_W] <= shreg_reg;
        GRP_WEN: wake_en_reg[lane +: PORT_W] <= shreg_reg;
        GRP_SEG: if (cmd_reg[1:0] == 2'h0) seg_join_reg <= shreg_reg[1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake status and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    clr_vec = ZERO32;
    if (wr_en && (grp == GRP_WSTS)) clr_vec[lane +: PORT_W] = shreg_reg;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_sts_reg <= ZERO32;
      irq_reg      <= 1'h0;
      low_reg      <= 1'h0;
    end else begin
      // edges set sticky status; a new edge beats a clear
      wake_sts_reg <= (wake_sts_reg & ~clr_vec) | edge_vec;
      // only ever pulls the shared line low
      irq_reg      <= |(wake_sts_reg & wake_en_reg);
      low_reg      <= 1'h0;
    end
  end

  assign smb_irq_out_n    = low_reg;
  assign smb_irq_out_n_oe = irq_reg;
  assign wake_pending     = irq_reg;

  // ----------------------------------------------------------------
  // Segment isolation
  // ----------------------------------------------------------------
  // Hold-off after each release stops the sync lag from latching the pair low
  for (genvar k = 0; k < 2 * NUM_SEG; k++) begin : g_seg
    logic [2:0] hold_reg;
    // clock and data follow one join bit
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        p2s_reg[k] <= 1'h0;
        s2p_reg[k] <= 1'h0;
        hold_reg   <= 3'h0;
      end else if (!seg_join_reg[k / 2]) begin
        p2s_reg[k] <= 1'h0;
        s2p_reg[k] <= 1'h0;
        hold_reg   <= 3'h0;
      end else if (p2s_reg[k]) begin
        if (bus_s2_reg[k % 2]) begin
          p2s_reg[k] <= 1'h0;
          hold_reg   <= HOLD_CYC;
        end
      end else if (s2p_reg[k]) begin
        if (seg_s2_reg[k]) begin
          s2p_reg[k] <= 1'h0;
          hold_reg   <= HOLD_CYC;
        end
      end else if (hold_reg != 3'h0) begin
        hold_reg <= hold_reg - 3'h1;
      end else if (!bus_s2_reg[k % 2]) begin
        p2s_reg[k] <= 1'h1;
      end else if (!seg_s2_reg[k]) begin
        s2p_reg[k] <= 1'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prim_oe_reg <= 2'h0;
    end else begin
      prim_oe_reg[0] <= s2p_reg[0] | s2p_reg[2];
      prim_oe_reg[1] <= sda_drv_reg | s2p_reg[1] | s2p_reg[3];
    end
  end

  assign primary_smb_clk_out  = low_reg;
  assign primary_smb_clk_oe   = prim_oe_reg[0];
  assign primary_smb_data_out = low_reg;
  assign primary_smb_data_oe  = prim_oe_reg[1];
  assign seg1_smb_clk_out     = low_reg;
  assign seg1_smb_clk_oe      = p2s_reg[0];
  assign seg1_smb_data_out    = low_reg;
  assign seg1_smb_data_oe     = p2s_reg[1];
  assign seg2_smb_clk_out     = low_reg;
  assign seg2_smb_clk_oe      = p2s_reg[2];
  assign seg2_smb_data_out    = low_reg;
  assign seg2_smb_data_oe     = p2s_reg[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence addr_byte_ok;
    rx_done && (phase_reg == PHASE_ADDR) && addr_match && !start_cond && !stop_cond;
  endsequence
  sequence ack_driven;
    (st_reg == ST_RX_ACK) && sda_drv_reg;
  endsequence

  a_strap_capture: assert property ($rose(strap_done_reg) |-> addr_lsb_reg == $past(strap_s2_reg))
    else $error("address bit not taken from strap");
  a_strap_hold: assert property ($rose(strap_done_reg) |=> $stable(addr_lsb_reg) [*8])
    else $error("address bit moved after capture");
  a_wake_either: assert property ((edge_vec != ZERO32) |=> ((wake_sts_reg & $past(edge_vec)) == $past(edge_vec)))
    else $error("pin edge lost from wake status");
  a_dir_reset: assert property (!dir_touched_reg |-> (dir_reg == ZERO32))
    else $error("pin became output without host write");
  a_seg_isolated: assert property (!seg_join_reg[0] |=> (p2s_reg[1:0] == 2'h0) && (s2p_reg[1:0] == 2'h0))
    else $error("isolated segment still forwarding");
  a_irq_low: assert property (!smb_irq_out_n)
    else $error("interrupt pin drives high");
  a_irq_follow: assert property ((wake_sts_reg & wake_en_reg) != ZERO32 |=> smb_irq_out_n_oe)
    else $error("interrupt not pulled for pending wake");
  a_addr_ack: assert property (addr_byte_ok |=> ack_driven ##1 prim_oe_reg[1])
    else $error("own address not acknowledged");

endmodule // shgb_gpio_block
`default_nettype wire

// ===== core/shgb_pkg.sv
package shgb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned NUM_PINS  = NUM_PORTS * PORT_W;
  localparam int unsigned NUM_SEG   = 2;
  localparam int unsigned CLK_MHZ   = 200;

  // ----------------------------------------------------------------
  // Slave address, command groups (cmd[7:2] group, cmd[1:0] port)
  // ----------------------------------------------------------------
  // Arbitrary upper six address bits
  localparam logic [5:0] ADDR_BASE_DEF = 6'h10;
  localparam logic [5:0] GRP_STATE     = 6'h00;
  localparam logic [5:0] GRP_LEVEL     = 6'h01;
  localparam logic [5:0] GRP_DIR       = 6'h02;
  localparam logic [5:0] GRP_OD        = 6'h03;
  localparam logic [5:0] GRP_WSTS      = 6'h04;
  localparam logic [5:0] GRP_WEN       = 6'h05;
  localparam logic [5:0] GRP_SEG       = 6'h06;

  // ----------------------------------------------------------------
  // Protocol and timing
  // ----------------------------------------------------------------
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [1:0]  PHASE_ADDR   = 2'h0;
  localparam logic [1:0]  PHASE_CMD    = 2'h1;
  localparam logic [1:0]  PHASE_DATA   = 2'h2;
  localparam logic [2:0]  HOLD_CYC     = 3'h4;
  localparam logic [1:0]  STRAP_SETTLE = 2'h2;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RX     = 3'h1,
    ST_RX_ACK = 3'h3,
    ST_TX     = 3'h2,
    ST_TX_ACK = 3'h6
  } shgb_state_e;

endpackage

// ===== core/shgb_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module shgb_pin_cell
  import shgb_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pin_in,
  input  wire logic dir,
  input  wire logic open_drain,
  input  wire logic level,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      state,
  output logic      edge_seen
);

  logic       s1_reg;
  logic       s2_reg;
  logic       s3_reg;
  logic [2:0] valid_reg;

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_reg    <= 1'h0;
      s2_reg    <= 1'h0;
      s3_reg    <= 1'h0;
      valid_reg <= 3'h0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      valid_reg <= {valid_reg[1:0], 1'h1};
    end
  end

  assign state = s2_reg;
  // either-edge detect; masked until the pipe holds real samples
  assign edge_seen = valid_reg[2] & (s2_reg ^ s3_reg);

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 1'h0;
      pin_oe  <= 1'h0;
    end else begin
      pin_out <= open_drain ? 1'h0 : level;
      pin_oe  <= dir & ~(open_drain & level);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_od_drive: assert property ((dir && open_drain) |=> (!pin_out && pin_oe == !$past(level)))
    else $error("open-drain pin drove high or wrong enable");
  a_input_hiz: assert property (!dir |=> !pin_oe)
    else $error("input pin has driver enabled");

endmodule // shgb_pin_cell
`default_nettype wire

// ===== verif/shgb_smb_host.sv
`timescale 1ns/1ps
`default_nettype none
module shgb_smb_host (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  logic tick;

  // ----
  // Link tick, lines released
  // ----
  initial begin
    tick = 1'h0;
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end

  // 48 ns tick; scl low two ticks, high one, ample for the slave sync
  always #24 tick = ~tick;

  task automatic bit_io(input logic b, output logic r);
    @(posedge tick) sda_oe <= ~b;
    @(posedge tick) scl_oe <= 1'h0;
    @(posedge tick) begin
      r = sda;
      scl_oe <= 1'h1;
    end
  endtask

  task automatic start();
    @(posedge tick) sda_oe <= 1'h0;
    @(posedge tick) scl_oe <= 1'h0;
    @(posedge tick) sda_oe <= 1'h1;
    @(posedge tick) scl_oe <= 1'h1;
  endtask

  task automatic stop();
    @(posedge tick) sda_oe <= 1'h1;
    @(posedge tick) scl_oe <= 1'h0;
    @(posedge tick) sda_oe <= 1'h0;
  endtask

  task automatic put_byte(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'h1, r);
    ok = ok & ~r;
  endtask

  // Single byte reads only, so the host always answers NACK
  task automatic get_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(1'h1, r);
  endtask

  task automatic write(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                       output logic ok);
    ok = 1'h1;
    start();
    put_byte({a, 1'h0}, ok);
    if (ok) begin
      put_byte(c, ok);
      put_byte(d, ok);
    end
    stop();
  endtask

  task automatic read(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                      output logic ok);
    ok = 1'h1;
    start();
    put_byte({a, 1'h0}, ok);
    put_byte(c, ok);
    start();
    put_byte({a, 1'h1}, ok);
    get_byte(d);
    stop();
  endtask
endmodule // shgb_smb_host
`default_nettype wire

// ===== verif/test_shgb_gpio_block.sv
`timescale 1ns/1ps
`default_nettype none
module test_shgb_gpio_block;
  import shgb_pkg::*;
  localparam logic [6:0] ADDR = {ADDR_BASE_DEF, 1'h1};
  logic       clock, nrst, smb_addr_lsb_strap, seg1_pull, seg2_pull, h_scl_oe, h_sda_oe, ok;
  logic       primary_smb_clk_in, primary_smb_clk_out, primary_smb_clk_oe;
  logic       primary_smb_data_in, primary_smb_data_out, primary_smb_data_oe;
  logic       seg1_smb_clk_in, seg1_smb_clk_out, seg1_smb_clk_oe;
  logic       seg1_smb_data_in, seg1_smb_data_out, seg1_smb_data_oe;
  logic       seg2_smb_clk_in, seg2_smb_clk_out, seg2_smb_clk_oe;
  logic       seg2_smb_data_in, seg2_smb_data_out, seg2_smb_data_oe;
  logic       smb_irq_out_n, smb_irq_out_n_oe, wake_pending;
  logic [7:0] io_port_a_in, io_port_a_out, io_port_a_oe, io_port_b_in, io_port_b_out;
  logic [7:0] io_port_b_oe, io_port_c_in, io_port_c_out, io_port_c_oe, io_port_d_in;
  logic [7:0] io_port_d_out, io_port_d_oe, rdat;
  int         n_mismatch, checks_done, cycles;

  // ----
  // Wired-AND lines with pull-ups
  // ----
  assign primary_smb_clk_in = ~(h_scl_oe | primary_smb_clk_oe);
  assign primary_smb_data_in = ~(h_sda_oe | primary_smb_data_oe);
  assign seg1_smb_clk_in = ~seg1_smb_clk_oe;
  assign seg1_smb_data_in = ~(seg1_pull | seg1_smb_data_oe);
  assign seg2_smb_clk_in = ~seg2_smb_clk_oe;
  assign seg2_smb_data_in = ~(seg2_pull | seg2_smb_data_oe);

  shgb_gpio_block u_shgb_gpio_block (.clock, .nrst, .smb_addr_lsb_strap,
    .primary_smb_clk_in, .primary_smb_clk_out, .primary_smb_clk_oe, .primary_smb_data_in,
    .primary_smb_data_out, .primary_smb_data_oe, .seg1_smb_clk_in, .seg1_smb_clk_out,
    .seg1_smb_clk_oe, .seg1_smb_data_in, .seg1_smb_data_out, .seg1_smb_data_oe,
    .seg2_smb_clk_in, .seg2_smb_clk_out, .seg2_smb_clk_oe, .seg2_smb_data_in,
    .seg2_smb_data_out, .seg2_smb_data_oe, .smb_irq_out_n, .smb_irq_out_n_oe, .wake_pending,
    .io_port_a_in, .io_port_a_out, .io_port_a_oe, .io_port_b_in, .io_port_b_out,
    .io_port_b_oe, .io_port_c_in, .io_port_c_out, .io_port_c_oe, .io_port_d_in,
    .io_port_d_out, .io_port_d_oe);

  shgb_smb_host u_shgb_smb_host (.scl(primary_smb_clk_in), .sda(primary_smb_data_in),
    .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));

  always #2.5 clock = ~clock;

  // ----
  // Checking and closing
  // ----
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Roughly 15k cycles of traffic expected
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    u_shgb_smb_host.write(ADDR, c, d, ok);
    check(ok, 1'h1);
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    u_shgb_smb_host.read(ADDR, c, rdat, ok);
    check(ok, 1'h1);
    check(rdat, exp);
  endtask

  initial begin
    {clock, nrst, seg1_pull, seg2_pull} = 4'h0;
    smb_addr_lsb_strap = 1'h1;
    {io_port_a_in, io_port_b_in, io_port_c_in} = 24'h000000;
    io_port_d_in = 8'h81;
    {n_mismatch, checks_done, cycles} = '0;
    wait_clk(11);
    check({io_port_a_oe, io_port_b_oe, io_port_c_oe, io_port_d_oe}, 32'h0);
    check(smb_irq_out_n_oe, 1'h0);
    @(posedge clock) nrst <= 1'h1;
    wait_clk(10);
    check({io_port_a_oe, io_port_b_oe, io_port_c_oe, io_port_d_oe}, 32'h0);
    u_shgb_smb_host.write({ADDR_BASE_DEF, 1'h0}, 8'h08, 8'hFF, ok);
    check(ok, 1'h0);
    check(io_port_a_oe, 8'h00);
    rd(8'h18, 8'h00);
    wr(8'h04, 8'hA5);
    wr(8'h08, 8'hFF);
    wait_clk(4);
    check({io_port_a_out, io_port_a_oe}, 16'hA5FF);
    wr(8'h0C, 8'hFF);
    wait_clk(4);
    check({io_port_a_out, io_port_a_oe}, 16'h005A);
    rd(8'h0C, 8'hFF);
    rd(8'h04, 8'hA5);
    @(posedge clock) io_port_b_in <= 8'h3C;
    wait_clk(10);
    rd(8'h01, 8'h3C);
    rd(8'h11, 8'h3C);
    wr(8'h15, 8'h01);
    wait_clk(4);
    check({smb_irq_out_n_oe, wake_pending}, 2'h0);
    for (int e = 0; e < 2; e++) begin
      @(posedge clock) io_port_b_in[0] <= ~io_port_b_in[0];
      wait_clk(8);
      check({smb_irq_out_n_oe, smb_irq_out_n, wake_pending}, 3'h5);
      wr(8'h11, 8'h01);
      wait_clk(4);
      check({smb_irq_out_n_oe, wake_pending}, 2'h0);
    end
    // Forwarding needs join bit; seg2 stays isolated throughout
    wr(8'h18, 8'h01);
    rd(8'h18, 8'h01);
    @(posedge clock) seg1_pull <= 1'h1;
    wait_clk(8);
    check(primary_smb_data_oe, 1'h1);
    check({primary_smb_clk_oe, seg1_smb_clk_oe, seg1_smb_data_oe, seg2_smb_data_oe}, 4'h0);
    @(posedge clock) seg1_pull <= 1'h0;
    wait_clk(12);
    check(primary_smb_data_oe, 1'h0);
    @(posedge clock) seg2_pull <= 1'h1;
    wait_clk(8);
    check(primary_smb_data_oe, 1'h0);
    @(posedge clock) seg2_pull <= 1'h0;
    wait_clk(12);
    // Mid-run reset, strap left to its pull-down
    @(posedge clock) begin
      nrst               <= 1'h0;
      smb_addr_lsb_strap <= 1'h0;
    end
    wait_clk(4);
    check({io_port_a_out, io_port_a_oe, io_port_b_oe, io_port_d_oe}, 32'h0);
    check({smb_irq_out_n_oe, wake_pending, primary_smb_data_oe}, 3'h0);
    @(posedge clock) nrst <= 1'h1;
    wait_clk(10);
    u_shgb_smb_host.write(ADDR, 8'h08, 8'hFF, ok);
    check(ok, 1'h0);
    u_shgb_smb_host.write({ADDR_BASE_DEF, 1'h0}, 8'h08, 8'h0F, ok);
    check(ok, 1'h1);
    wait_clk(4);
    check({io_port_a_out, io_port_a_oe}, 16'h000F);
    check({primary_smb_clk_out, primary_smb_data_out, seg1_smb_clk_out, seg1_smb_data_out,
           seg2_smb_clk_out, seg2_smb_data_out, smb_irq_out_n}, 7'h00);
    finish_test();
  end
endmodule // test_shgb_gpio_block
`default_nettype wire
